// ---- nvs_host.sv ----
`timescale 1ns/100ps

module nvs_host #(
    parameter int SAVE_CYC = nvs_pkg::NVS_SAVE_CYC,
    parameter int PWRUP_CYC = nvs_pkg::NVS_PWRUP_CYC,
    parameter int RESTORE_CYC = nvs_pkg::NVS_RESTORE_CYC
) (
    input wire logic ref_clk_i,
    input wire logic rst_b_i,
    input wire logic req_i,
    input wire nvs_pkg::nvs_op_t req_op_i,
    input wire logic [nvs_pkg::NVS_ADDR_W-1:0] req_addr_i,
    input wire logic [nvs_pkg::NVS_DATA_W-1:0] req_wdata_i,
    output logic busy_o,
    output logic done_o,
    output logic [nvs_pkg::NVS_DATA_W-1:0] rdata_o,
    output logic chip_sel_b_o,
    output logic out_en_b_o,
    output logic write_en_b_o,
    output logic [nvs_pkg::NVS_ADDR_W-1:0] address_lines_o,
    output logic [nvs_pkg::NVS_DATA_W-1:0] data_lines_o,
    output logic data_lines_oe_o,
    input wire logic [nvs_pkg::NVS_DATA_W-1:0] data_lines_i
);
    import nvs_pkg::*;

    // counts the logic can hold
    initial
    begin
        if (SAVE_CYC < 1 || SAVE_CYC >= (1 << NVS_CNT_W) || PWRUP_CYC < 1 ||
            PWRUP_CYC >= (1 << NVS_CNT_W) || RESTORE_CYC < 1 ||
            RESTORE_CYC >= (1 << NVS_CNT_W))
        begin
            $error("nvs_host: wait count out of range");
        end
    end

    // controller states
    typedef enum logic [2:0]
    {
        ST_PWRUP = 3'b000,
        ST_IDLE = 3'b001,
        ST_SETUP = 3'b010,
        ST_STROBE = 3'b011,
        ST_RECOVER = 3'b100,
        ST_NVWAIT = 3'b101
    } nvs_state_t;

    localparam logic [NVS_CNT_W-1:0] RD_LOAD = NVS_CNT_W'(NVS_ACCESS_CYC + NVS_SYNC_CYC - 1);
    localparam logic [NVS_CNT_W-1:0] WR_LOAD = NVS_CNT_W'(NVS_WPULSE_CYC - 1);
    localparam logic [NVS_CNT_W-1:0] SAVE_LOAD = NVS_CNT_W'(SAVE_CYC - 1);
    localparam logic [NVS_CNT_W-1:0] REST_LOAD = NVS_CNT_W'(RESTORE_CYC - 1);
    localparam logic [NVS_CNT_W-1:0] PWRUP_LOAD = NVS_CNT_W'(PWRUP_CYC - 1);

    nvs_state_t state_r; // current state
    nvs_state_t state_nxt; // next state
    logic [NVS_CNT_W-1:0] cnt_r; // down counter of the current phase
    logic [NVS_CNT_W-1:0] cnt_nxt;
    nvs_op_t op_r; // latched request kind
    logic [2:0] step_r; // software sequence step
    logic [NVS_DATA_W-1:0] din_meta_r; // first synchroniser stage
    logic [NVS_DATA_W-1:0] din_sync_r; // second synchroniser stage
    logic busy_r;
    logic done_r;
    logic [NVS_DATA_W-1:0] rdata_r;
    logic cs_b_r;
    logic oe_b_r;
    logic we_b_r;
    logic [NVS_ADDR_W-1:0] pin_addr_r;
    logic [NVS_DATA_W-1:0] pin_data_r;
    logic pin_oe_r;

    // decoded conditions
    wire cnt_zero = (cnt_r == '0);
    wire is_seq = op_r[1]; // save or restore request
    wire is_write = (op_r == NVS_OP_WRITE);
    wire seq_last = (step_r == NVS_SEQ_LAST);
    wire take_req = (state_r == ST_IDLE) && req_i;
    // address of the next strobe: the user's, or the next code of a sequence
    wire [NVS_ADDR_W-1:0] next_addr = take_req ?
        (req_op_i[1] ? nvs_seq_addr(3'h0, req_op_i[0]) : req_addr_i) :
        nvs_seq_addr(step_r + 3'h1, op_r[0]);
    wire strobe_end = (state_r == ST_STROBE) && cnt_zero;
    wire finish = ((state_r == ST_RECOVER) && !is_seq) ||
                  ((state_r == ST_NVWAIT) && cnt_zero);

    // next state and counter
    always_comb
    begin
        state_nxt = state_r;
        cnt_nxt = cnt_zero ? cnt_r : cnt_r - 1'b1;
        case (state_r)
            ST_PWRUP, ST_NVWAIT:
            begin
                // wait out the power-up restore or a copy before any access
                if (cnt_zero)
                begin
                    state_nxt = ST_IDLE;
                end
            end
            ST_IDLE:
            begin
                if (req_i)
                begin
                    state_nxt = ST_SETUP;
                end
            end
            ST_SETUP:
            begin
                // strobe length by kind
                state_nxt = ST_STROBE;
                cnt_nxt = is_write ? WR_LOAD : RD_LOAD;
            end
            ST_STROBE:
            begin
                if (cnt_zero)
                begin
                    state_nxt = ST_RECOVER;
                end
            end
            ST_RECOVER:
            begin
                if (!is_seq)
                begin
                    state_nxt = ST_IDLE;
                end
                else if (!seq_last)
                begin
                    // next code read, nothing else in between
                    state_nxt = ST_SETUP;
                end
                else
                begin
                    // device busy with the copy, stay off its pins
                    state_nxt = ST_NVWAIT;
                    cnt_nxt = op_r[0] ? REST_LOAD : SAVE_LOAD;
                end
            end
            default:
            begin
                state_nxt = ST_IDLE;
            end
        endcase
    end

    // state register
    always_ff @(posedge ref_clk_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
        begin
            state_r <= ST_PWRUP;
            cnt_r <= PWRUP_LOAD;
        end
        else
        begin
            state_r <= state_nxt;
            cnt_r <= cnt_nxt;
        end
    end

    // request latch and sequence step
    always_ff @(posedge ref_clk_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
        begin
            op_r <= NVS_OP_READ;
            step_r <= 3'h0;
        end
        else if (take_req)
        begin
            op_r <= req_op_i;
            step_r <= 3'h0; // always start at the first code
        end
        else if ((state_r == ST_RECOVER) && is_seq && !seq_last)
        begin
            step_r <= step_r + 3'h1;
        end
    end

    // data pin synchroniser
    always_ff @(posedge ref_clk_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
        begin
            din_meta_r <= NVS_DATA_RST;
            din_sync_r <= NVS_DATA_RST;
        end
        else
        begin
            din_meta_r <= data_lines_i;
            din_sync_r <= din_meta_r;
        end
    end

    // user side status and read data
    always_ff @(posedge ref_clk_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
        begin
            busy_r <= 1'b1;
            done_r <= 1'b0;
            rdata_r <= NVS_DATA_RST;
        end
        else
        begin
            busy_r <= (state_nxt != ST_IDLE);
            done_r <= finish;
            if (strobe_end && (op_r == NVS_OP_READ))
            begin
                rdata_r <= din_sync_r;
            end
        end
    end

    // memory control pins
    always_ff @(posedge ref_clk_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
        begin
            cs_b_r <= 1'b1;
            oe_b_r <= 1'b1;
            we_b_r <= 1'b1;
        end
        else if (state_r == ST_SETUP)
        begin
            // sequence reads keep write high and output enable high
            cs_b_r <= 1'b0;
            oe_b_r <= !(op_r == NVS_OP_READ);
            we_b_r <= !is_write;
        end
        else if (strobe_end)
        begin
            cs_b_r <= 1'b1;
            oe_b_r <= 1'b1;
            we_b_r <= 1'b1;
        end
    end

    // address and data pins, changed only while deselected
    always_ff @(posedge ref_clk_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
        begin
            pin_addr_r <= NVS_ADDR_RST;
            pin_data_r <= NVS_DATA_RST;
            pin_oe_r <= 1'b0;
        end
        else if (take_req)
        begin
            // address and data settle a cycle before select falls
            pin_addr_r <= next_addr;
            pin_data_r <= req_wdata_i;
            pin_oe_r <= (req_op_i == NVS_OP_WRITE);
        end
        else if (state_r == ST_RECOVER)
        begin
            // select is already high here, so the address may move
            pin_oe_r <= 1'b0;
            if (is_seq && !seq_last)
            begin
                pin_addr_r <= next_addr;
            end
        end
    end

    assign busy_o = busy_r;
    assign done_o = done_r;
    assign rdata_o = rdata_r;
    assign chip_sel_b_o = cs_b_r;
    assign out_en_b_o = oe_b_r;
    assign write_en_b_o = we_b_r;
    assign address_lines_o = pin_addr_r;
    assign data_lines_o = pin_data_r;
    assign data_lines_oe_o = pin_oe_r;

    // checks on the pins this controller drives
    AST_READ_PINS: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i)
        (!cs_b_r && !oe_b_r) |-> (we_b_r && !pin_oe_r))
        else $error("read strobe with write low or bus driven");
    AST_ADDR_STABLE: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i)
        (!cs_b_r && $past(!cs_b_r)) |-> $stable(pin_addr_r))
        else $error("address moved while selected");
    AST_WRITE_OE_HIGH: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i)
        !we_b_r |-> (oe_b_r && pin_oe_r && !cs_b_r))
        else $error("write with output enable low or data undriven");
    AST_WRITE_LEN: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i)
        $fell(we_b_r) |-> (!we_b_r)[*2] ##1 (we_b_r && cs_b_r && pin_oe_r) ##1 !pin_oe_r)
        else $error("write pulse length or data hold wrong");
    AST_SEQ_WE_HIGH: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i)
        (!cs_b_r && is_seq) |-> (we_b_r && oe_b_r))
        else $error("sequence step not a plain read");
    AST_SEQ_FIRST: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i)
        ($fell(cs_b_r) && is_seq && step_r == 3'h0) |-> (pin_addr_r[13:0] == 14'h0E38))
        else $error("sequence did not start at first code");
    AST_SEQ_LAST: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i)
        ($fell(cs_b_r) && is_seq && seq_last) |->
        (pin_addr_r[13:0] == (op_r[0] ? 14'h0C63 : 14'h0FC0)))
        else $error("sixth code address wrong");
    AST_NV_QUIET: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i)
        $rose(state_r == ST_NVWAIT) |-> (cs_b_r && we_b_r && !pin_oe_r)[*8])
        else $error("pins touched during nonvolatile copy");
    AST_PWRUP_QUIET: assert property (@(posedge ref_clk_i) disable iff (!rst_b_i)
        (state_r == ST_PWRUP) |-> (cs_b_r && we_b_r && busy_r))
        else $error("access during power-up restore");

    COV_READ: cover property (@(posedge ref_clk_i) disable iff (!rst_b_i)
        done_r && op_r == NVS_OP_READ);
    COV_WRITE: cover property (@(posedge ref_clk_i) disable iff (!rst_b_i)
        done_r && op_r == NVS_OP_WRITE);
    COV_SAVE: cover property (@(posedge ref_clk_i) disable iff (!rst_b_i)
        done_r && op_r == NVS_OP_SAVE);
    COV_RESTORE: cover property (@(posedge ref_clk_i) disable iff (!rst_b_i)
        done_r && op_r == NVS_OP_RESTORE);

endmodule // nvs_host

// ---- nvs_pkg.sv ----
package nvs_pkg;

    // host request kinds
    typedef enum logic [1:0]
    {
        NVS_OP_READ = 2'b00,
        NVS_OP_WRITE = 2'b01,
        NVS_OP_SAVE = 2'b10,
        NVS_OP_RESTORE = 2'b11
    } nvs_op_t;

    // widths of the memory pins and of the wait counter
    localparam int NVS_ADDR_W = 15;
    localparam int NVS_DATA_W = 8;
    localparam int NVS_CNT_W = 20;

    // clock period and pin timing in their own units
    localparam int NVS_CLK_NS = 20;
    localparam int NVS_ACCESS_NS = 55;
    localparam int NVS_WPULSE_NS = 40;
    localparam int NVS_SAVE_MS = 10;
    localparam int NVS_RESTORE_US = 20;
    localparam int NVS_PWRUP_US = 550;

    // derived cycle counts, least times rounded up
    localparam int NVS_ACCESS_CYC = (NVS_ACCESS_NS + NVS_CLK_NS - 1) / NVS_CLK_NS;
    localparam int NVS_WPULSE_CYC = (NVS_WPULSE_NS + NVS_CLK_NS - 1) / NVS_CLK_NS;
    localparam int NVS_SAVE_CYC = (NVS_SAVE_MS * 1000000 + NVS_CLK_NS - 1) / NVS_CLK_NS;
    localparam int NVS_RESTORE_CYC = (NVS_RESTORE_US * 1000 + NVS_CLK_NS - 1) / NVS_CLK_NS;
    localparam int NVS_PWRUP_CYC = (NVS_PWRUP_US * 1000 + NVS_CLK_NS - 1) / NVS_CLK_NS;
    // read strobe covers access time plus the two-stage input synchroniser
    localparam int NVS_SYNC_CYC = 3;

    // software sequence codes on the low address bits
    localparam logic [13:0] NVS_SEQ0 = 14'h0E38;
    localparam logic [13:0] NVS_SEQ1 = 14'h31C7;
    localparam logic [13:0] NVS_SEQ2 = 14'h03E0;
    localparam logic [13:0] NVS_SEQ3 = 14'h3C1F;
    localparam logic [13:0] NVS_SEQ4 = 14'h303F;
    localparam logic [13:0] NVS_SEQ_SAVE = 14'h0FC0;
    localparam logic [13:0] NVS_SEQ_RESTORE = 14'h0C63;
    localparam logic [2:0] NVS_SEQ_LAST = 3'h5;

    // values after reset
    localparam logic [NVS_ADDR_W-1:0] NVS_ADDR_RST = 15'h0000;
    localparam logic [NVS_DATA_W-1:0] NVS_DATA_RST = 8'h00;

    // address of one step of the software sequence
    function automatic logic [NVS_ADDR_W-1:0] nvs_seq_addr(input logic [2:0] step,
                                                           input logic restore);
        logic [13:0] code;
        code = NVS_SEQ0;
        case (step)
            3'h0: code = NVS_SEQ0;
            3'h1: code = NVS_SEQ1;
            3'h2: code = NVS_SEQ2;
            3'h3: code = NVS_SEQ3;
            3'h4: code = NVS_SEQ4;
            default: code = restore ? NVS_SEQ_RESTORE : NVS_SEQ_SAVE;
        endcase
        return {1'b0, code};
    endfunction

endpackage

// ---- nvs_mem_model.sv ----
`timescale 1ns/100ps

// behavioural battery-free static memory with a shadow array, seen from its pins
module nvs_mem_model #(
    parameter int SAVE_NS = 600,
    parameter int RESTORE_NS = 150
) (
    input wire logic chip_sel_b_i,
    input wire logic out_en_b_i,
    input wire logic write_en_b_i,
    input wire logic [nvs_pkg::NVS_ADDR_W-1:0] address_lines_i,
    input wire logic [nvs_pkg::NVS_DATA_W-1:0] data_lines_i,
    output logic [nvs_pkg::NVS_DATA_W-1:0] data_lines_o,
    output logic data_lines_oe_o
);
    import nvs_pkg::*;

    logic [NVS_DATA_W-1:0] sram [0:(1<<NVS_ADDR_W)-1]; // volatile cells
    logic [NVS_DATA_W-1:0] nv [0:(1<<NVS_ADDR_W)-1]; // nonvolatile shadow cells
    logic nv_busy = 1'b0; // a copy between the arrays is running
    logic [NVS_DATA_W-1:0] last_q = NVS_DATA_RST; // last byte put on the pins
    logic [2:0] step = 3'h0; // position in the software sequence
    logic [13:0] want; // code expected at this step
    wire [13:0] low_addr = address_lines_i[13:0];
    // read drive needs write high and no copy running
    wire rd_sel = !chip_sel_b_i && !out_en_b_i && write_en_b_i && !nv_busy;
    wire rd_step = !chip_sel_b_i && write_en_b_i && !nv_busy; // select-driven read
    wire wr_act = !chip_sel_b_i && !write_en_b_i && !nv_busy; // write in progress

    assign want = (step == 3'h0) ? NVS_SEQ0 : (step == 3'h1) ? NVS_SEQ1 :
        (step == 3'h2) ? NVS_SEQ2 : (step == 3'h3) ? NVS_SEQ3 : NVS_SEQ4;
    // data follows the address; released pins show the inverse of the last byte
    assign data_lines_o = rd_sel ? sram[address_lines_i] : ~last_q;
    assign data_lines_oe_o = rd_sel;

    // both arrays start cleared, the power-up copy leaves them equal
    initial
    begin
        foreach (nv[i]) nv[i] = NVS_DATA_RST;
        sram = nv;
    end

    // remember what was last driven
    always @(rd_sel or address_lines_i)
        if (rd_sel) last_q = sram[address_lines_i];

    // a copy ignores every input until it ends
    task automatic run_nv(input logic save);
        step = 3'h0;
        nv_busy = 1'b1;
        if (save)
        begin
            foreach (nv[i]) nv[i] = 8'hFF;
            #(SAVE_NS);
            // a software save copies whether or not anything was written
            nv = sram;
        end
        else
        begin
            foreach (sram[i]) sram[i] = NVS_DATA_RST;
            #(RESTORE_NS);
            sram = nv;
        end
        nv_busy = 1'b0;
    endtask

    // write takes the bus at the first strobe to rise and aborts any sequence
    always @(negedge wr_act)
    begin
        sram[address_lines_i] = data_lines_i;
        step = 3'h0;
    end

    // sequence steps are taken when select rises after a read
    always @(negedge rd_step)
    begin
        if (chip_sel_b_i && write_en_b_i)
        begin
            if (step == NVS_SEQ_LAST && low_addr == NVS_SEQ_SAVE)
                run_nv(1'b1);
            else if (step == NVS_SEQ_LAST && low_addr == NVS_SEQ_RESTORE)
                run_nv(1'b0);
            else if (step != NVS_SEQ_LAST && low_addr == want)
                step = step + 3'h1;
            else
                step = (low_addr == NVS_SEQ0) ? 3'h1 : 3'h0;
        end
    end
endmodule // nvs_mem_model

// ---- test_nvs_host.sv ----
`timescale 1ns/100ps
`define NVS_CHK(got, exp) begin num_checks++; if ((got) !== (exp)) begin n_mismatch++; \
    $display("wrong value at %0t: got %h expected %h", $time, (got), (exp)); end end

// host controller against the memory model, results checked from a queue
module test_nvs_host;
    import nvs_pkg::*;
    localparam int SAVE_C = 40; // shortened save wait
    localparam int RESTORE_C = 10; // shortened restore wait
    localparam int PWRUP_C = 20; // shortened power-up wait
    // one expected outcome per request
    typedef struct packed
    {
        logic is_rd;
        logic [NVS_DATA_W-1:0] data;
    } nvs_note_t;
    logic clk = 1'b0;
    logic rst_b = 1'b0;
    logic req = 1'b0;
    nvs_op_t req_op = NVS_OP_READ;
    logic [NVS_ADDR_W-1:0] req_addr = NVS_ADDR_RST;
    logic [NVS_DATA_W-1:0] req_wdata = NVS_DATA_RST;
    logic busy, done, cs_b, oe_b, we_b, host_oe, mem_oe; // pins and status
    logic [NVS_DATA_W-1:0] rdata, host_q, mem_q, bus;
    logic [NVS_ADDR_W-1:0] pin_addr, held_addr, a;
    logic [NVS_DATA_W-1:0] shadow [0:(1<<NVS_ADDR_W)-1]; // expected volatile cells
    logic [NVS_DATA_W-1:0] nv_sh [0:(1<<NVS_ADDR_W)-1]; // expected shadow cells
    logic [15:0] rnd = 16'h5C74; // random state
    logic in_seq = 1'b0; // a software sequence is running
    nvs_note_t notes [$];
    nvs_note_t note;
    int n_mismatch = 0;
    int num_checks = 0;

    // the shared data wire
    assign bus = host_oe ? host_q : mem_q;

    always #10 clk = ~clk;

    nvs_host #(.SAVE_CYC(SAVE_C), .PWRUP_CYC(PWRUP_C), .RESTORE_CYC(RESTORE_C)) dut (
        .ref_clk_i(clk), .rst_b_i(rst_b), .req_i(req), .req_op_i(req_op),
        .req_addr_i(req_addr), .req_wdata_i(req_wdata), .busy_o(busy), .done_o(done),
        .rdata_o(rdata), .chip_sel_b_o(cs_b), .out_en_b_o(oe_b), .write_en_b_o(we_b),
        .address_lines_o(pin_addr), .data_lines_o(host_q), .data_lines_oe_o(host_oe),
        .data_lines_i(bus));

    nvs_mem_model #(.SAVE_NS(SAVE_C * NVS_CLK_NS - 100), .RESTORE_NS(RESTORE_C * NVS_CLK_NS - 50)) mem (
        .chip_sel_b_i(cs_b), .out_en_b_i(oe_b), .write_en_b_i(we_b), .address_lines_i(pin_addr),
        .data_lines_i(bus), .data_lines_o(mem_q), .data_lines_oe_o(mem_oe));

    // next random state
    function automatic logic [15:0] lfsr(input logic [15:0] s);
        return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
    endfunction

    // note the outcome, hand one request over and wait for its end
    task automatic do_req(input nvs_op_t op, input logic [NVS_ADDR_W-1:0] ad,
                          input logic [NVS_DATA_W-1:0] wd);
        notes.push_back({op == NVS_OP_READ, shadow[ad]});
        do @(negedge clk); while (busy !== 1'b0);
        @(posedge clk);
        req <= 1'b1;
        req_op <= op;
        req_addr <= ad;
        req_wdata <= wd;
        in_seq <= op[1];
        @(posedge clk);
        req <= 1'b0;
        do @(negedge clk); while (done !== 1'b1);
        in_seq <= 1'b0;
    endtask

    // write one byte and note it
    task automatic wr(input logic [NVS_ADDR_W-1:0] ad, input logic [NVS_DATA_W-1:0] wd);
        shadow[ad] = wd;
        do_req(NVS_OP_WRITE, ad, wd);
    endtask

    // print the verdict and stop
    task automatic give_verdict();
        if (n_mismatch == 0 && num_checks > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask

    // result and pin watcher
    always @(negedge clk)
    begin
        if (done === 1'b1)
        begin
            `NVS_CHK(notes.size() != 0, 1'b1)
            if (notes.size() != 0)
            begin
                note = notes.pop_front();
                if (note.is_rd)
                    `NVS_CHK(rdata, note.data)
            end
        end
        if (host_oe === 1'b1)
            `NVS_CHK(mem_oe, 1'b0)
        if (in_seq === 1'b1)
            `NVS_CHK(we_b, 1'b1)
        if (cs_b !== 1'b0)
            held_addr = pin_addr;
        else
            `NVS_CHK(pin_addr, held_addr)
    end

    // main sequence
    initial
    begin
        foreach (shadow[i]) shadow[i] = NVS_DATA_RST;
        nv_sh = shadow;
        repeat (3) @(posedge clk);
        rst_b <= 1'b1;
        // strobes stay idle through the power-up wait
        repeat (PWRUP_C - 2)
        begin
            @(negedge clk);
            `NVS_CHK({busy, cs_b, we_b}, 3'h7)
        end
        // random writes read back at once, and the twin address on the top line
        for (int k = 0; k < 12; k++)
        begin
            rnd = lfsr(rnd);
            a = (k == 0) ? 15'h7FFF : rnd[14:0];
            wr(a, rnd[7:0] ^ rnd[15:8]);
            do_req(NVS_OP_READ, a, 8'h00);
            do_req(NVS_OP_READ, a ^ 15'h4000, 8'h00);
        end
        // save, overwrite, restore, twice over
        for (int k = 0; k < 2; k++)
        begin
            rnd = lfsr(rnd);
            a = rnd[14:0];
            wr(a, rnd[15:8]);
            do_req(NVS_OP_SAVE, a, 8'h00);
            nv_sh = shadow;
            wr(a, ~rnd[15:8]);
            do_req(NVS_OP_READ, a, 8'h00);
            do_req(NVS_OP_RESTORE, a, 8'h00);
            shadow = nv_sh;
            do_req(NVS_OP_READ, a, 8'h00);
            do_req(NVS_OP_READ, 15'h7FFF, 8'h00);
        end
        // a second restore in a row leaves the shadow cells alone
        do_req(NVS_OP_RESTORE, a, 8'h00);
        do_req(NVS_OP_READ, a, 8'h00);
        give_verdict();
    end

    // cut a hang short
    initial
    begin
        #200000;
        n_mismatch++;
        give_verdict();
    end
endmodule // test_nvs_host
